// ===== verilog/fcp_pkg.sv
`default_nettype none
package fcp_pkg;
	localparam int WORD_W = 32;
	localparam int PROD_W = 64;
	localparam int NREG   = 8;

	typedef enum logic [1:0] {
		FCP_OP_NOP   = 2'h0,
		FCP_OP_FIX   = 2'h1,
		FCP_OP_FLT   = 2'h3,
		FCP_OP_MULTI = 2'h2
	} fcp_op_t;

	typedef enum logic [1:0] {
		FCP_LD_IDLE  = 2'h0,
		FCP_LD_LOAD  = 2'h1,
		FCP_LD_KEEP  = 2'h3,
		FCP_LD_GUARD = 2'h2
	} fcp_ld_t;

	localparam logic [2:0] OP_TIME = 3'h4;
	localparam logic [2:0] CNT_ONE = 3'h1;

	localparam logic [1:0] CFG_ONE_X = 2'h1;
	localparam logic [1:0] CFG_ONE_Y = 2'h2;
	localparam logic [7:0] FALL_ONE  = 8'hF0;
	localparam logic [7:0] FALL_TWO  = 8'hAA;

	localparam int         EXP_MSB  = 30;
	localparam int         EXP_LSB  = 23;
	localparam int         FRAC_MSB = 22;
	localparam logic [9:0] EXP_BIAS = 10'h07F;
	localparam logic [9:0] EXP_MIN  = 10'h001;

	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_GO    = 8'h04;
	localparam logic [7:0] A_SEL   = 8'h08;
	localparam logic [7:0] A_DATAX = 8'h0C;
	localparam logic [7:0] A_DATAY = 8'h10;
	localparam logic [7:0] A_RESLO = 8'h14;
	localparam logic [7:0] A_RESHI = 8'h18;
	localparam logic [7:0] A_STAT  = 8'h1C;

	localparam int C_ASG  = 0;
	localparam int C_BSG  = 1;
	localparam int C_SHL  = 2;
	localparam int C_FAST = 3;
	localparam int C_OP   = 4;
	localparam int C_RDA  = 6;
	localparam int C_RDB  = 8;
	localparam int C_CFG  = 10;
	localparam int C_RST  = 12;
	localparam int C_HOLD = 13;
	localparam int C_GRAD = 14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	localparam int ST_DONE = 0;
	localparam int ST_BUSY = 1;
endpackage
`default_nettype wire

// ===== verilog/fcp_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fcp_link_if (
	input wire logic pclk
);
	logic        reset_n;
	logic        hold_n;
	logic        operand_a_signed_sel;
	logic        operand_b_signed_sel;
	logic        product_shift_left;
	logic        fast_mode;
	logic [1:0]  op;
	logic [1:0]  rd_a;
	logic [1:0]  rd_b;
	logic [1:0]  input_port_config;
	logic [7:0]  register_load_select;
	logic [31:0] port_x;
	logic [31:0] port_y;
	logic [63:0] dout;
	logic        dout_valid;

	modport dev (
		input  pclk, reset_n, hold_n, operand_a_signed_sel, operand_b_signed_sel,
		input  product_shift_left, fast_mode, op, rd_a, rd_b, input_port_config,
		input  register_load_select, port_x, port_y,
		output dout, dout_valid
	);
	modport seq (
		input  pclk, dout, dout_valid,
		output reset_n, hold_n, operand_a_signed_sel, operand_b_signed_sel,
		output product_shift_left, fast_mode, op, rd_a, rd_b, input_port_config,
		output register_load_select, port_x, port_y
	);
endinterface
`default_nettype wire

// ===== verilog/fcp_input_regs.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_input_regs (
	input  wire logic        pclk,
	input  wire logic [1:0]  port_cfg,
	input  wire logic [7:0]  load_sel,
	input  wire logic [31:0] port_x,
	input  wire logic [31:0] port_y,
	input  wire logic [1:0]  rd_a,
	input  wire logic [1:0]  rd_b,
	output logic      [31:0] opnd_a,
	output logic      [31:0] opnd_b
);
	logic [7:0]  sel_lat;
	logic [31:0] rise_q [fcp_pkg::NREG];
	logic [31:0] fall_q [fcp_pkg::NREG];
	// Toggle pairs start equal so the first load on either edge selects its copy
	logic [7:0]  rt_q = 8'h00;
	logic [7:0]  ft_q = 8'h00;
	wire         one_port = (port_cfg == fcp_pkg::CFG_ONE_X) || (port_cfg == fcp_pkg::CFG_ONE_Y);
	wire  [31:0] one_word = (port_cfg == fcp_pkg::CFG_ONE_Y) ? port_y : port_x;
	wire  [31:0] a_word   = one_port ? one_word : port_x;
	wire  [31:0] b_word   = one_port ? one_word : port_y;
	wire  [7:0]  fall_msk = one_port ? fcp_pkg::FALL_ONE : fcp_pkg::FALL_TWO;

	// Each register keeps a rising and a falling copy; toggles mark the newer one
	function automatic logic [31:0] cur(input logic [2:0] i);
		cur = (rt_q[i] != ft_q[i]) ? rise_q[i] : fall_q[i];
	endfunction

	// Transparent while clock low, holds while high
	always_latch
	begin
		if (!pclk)
			sel_lat = load_sel;
	end

	// No reset: input register contents survive the control reset
	always_ff @(posedge pclk)
	begin
		for (int i = 0; i < fcp_pkg::NREG; i++)
			if (sel_lat[i] && !fall_msk[i])
			begin
				rise_q[i] <= (i >= 4) ? b_word : a_word;
				rt_q[i]   <= ~ft_q[i];
			end
	end

	always_ff @(negedge pclk)
	begin
		for (int i = 0; i < fcp_pkg::NREG; i++)
			if (sel_lat[i] && fall_msk[i])
			begin
				fall_q[i] <= (i >= 4) ? b_word : a_word;
				ft_q[i]   <= rt_q[i];
			end
	end

	assign opnd_a = cur({1'b0, rd_a});
	assign opnd_b = cur({1'b1, rd_b});
endmodule
`default_nettype wire

// ===== verilog/fcp_device.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_device (
	fcp_link_if.dev   lnk,
	output logic      busy,
	output logic      flush_zero
);
	logic              c1_v_q;
	fcp_pkg::fcp_op_t  c1_op_q;
	logic              c1_asg_q;
	logic              c1_bsg_q;
	logic              c1_shl_q;
	logic              c1_fast_q;
	logic [31:0]       c1_a_q;
	logic [31:0]       c1_b_q;
	logic              s2_v_q;
	fcp_pkg::fcp_op_t  s2_op_q;
	logic              s2_shl_q;
	logic              s2_flush_q;
	logic [63:0]       s2_prod_q;
	logic [31:0]       s2_flt_q;
	logic [2:0]        cnt_q;
	logic              valid_q;
	logic              flush_q;
	logic [63:0]       dout_q;
	logic [31:0]       opnd_a;
	logic [31:0]       opnd_b;

	fcp_input_regs u_regs (
		.pclk     (lnk.pclk),
		.port_cfg (lnk.input_port_config),
		.load_sel (lnk.register_load_select),
		.port_x   (lnk.port_x),
		.port_y   (lnk.port_y),
		.rd_a     (lnk.rd_a),
		.rd_b     (lnk.rd_b),
		.opnd_a   (opnd_a),
		.opnd_b   (opnd_b)
	);

	function automatic logic [32:0] ext33(input logic [31:0] v, input logic sg);
		ext33 = {sg & v[31], v};
	endfunction

	function automatic logic is_denorm(input logic [31:0] v);
		is_denorm = (v[fcp_pkg::EXP_MSB:fcp_pkg::EXP_LSB] == 8'h00) && (v[fcp_pkg::FRAC_MSB:0] != 23'h0);
	endfunction

	function automatic logic [23:0] mant(input logic [31:0] v);
		mant = {v[fcp_pkg::EXP_MSB:fcp_pkg::EXP_LSB] != 8'h00, v[fcp_pkg::FRAC_MSB:0]};
	endfunction

	// Hold low freezes every stage; only valid_q and flush_q clear to 0 while held
	wire adv   = lnk.hold_n;
	wire blk   = (cnt_q != 3'h0);
	wire take  = adv && !blk;
	wire s2_st = s2_v_q && (s2_op_q == fcp_pkg::FCP_OP_MULTI) && (cnt_q != fcp_pkg::CNT_ONE);
	wire fire  = adv && s2_v_q && !s2_st;

	// Fixed-point product; signedness per operand
	wire signed [65:0] fx_full = $signed(ext33(c1_a_q, c1_asg_q)) * $signed(ext33(c1_b_q, c1_bsg_q));
	wire        [63:0] fx_prod = fx_full[63:0];

	// Single-precision product, truncated
	wire        [47:0] mp      = mant(c1_a_q) * mant(c1_b_q);
	wire               nrm     = mp[47];
	wire        [22:0] fmant   = nrm ? mp[46:24] : mp[45:23];
	wire        [9:0]  fexp    = 10'(c1_a_q[fcp_pkg::EXP_MSB:fcp_pkg::EXP_LSB])
	                           + 10'(c1_b_q[fcp_pkg::EXP_MSB:fcp_pkg::EXP_LSB])
	                           - fcp_pkg::EXP_BIAS + 10'(nrm);
	wire               tiny    = $signed(fexp) < $signed(fcp_pkg::EXP_MIN);
	wire               dn_in   = is_denorm(c1_a_q) || is_denorm(c1_b_q);
	wire               f_flush = c1_fast_q && (tiny || dn_in);
	wire               f_zero  = f_flush || (mp == 48'h0);
	wire               f_sign  = c1_a_q[31] ^ c1_b_q[31];
	// Without fast mode a tiny exponent wraps; software handles it as an exception
	wire        [31:0] f_res   = f_zero ? {f_sign, 31'h0} : {f_sign, fexp[7:0], fmant};

	// Shift applied just before the output register
	wire        [63:0] fx_out  = s2_shl_q ? {s2_prod_q[62:0], 1'b0} : s2_prod_q;
	wire        [63:0] dout_d  = (s2_op_q == fcp_pkg::FCP_OP_FLT) ? {32'h0, s2_flt_q} : fx_out;

	// Input control register and control pipeline
	always_ff @(posedge lnk.pclk or negedge lnk.reset_n)
	begin
		if (!lnk.reset_n)
		begin
			c1_v_q    <= 1'b0;
			c1_op_q   <= fcp_pkg::FCP_OP_NOP;
			c1_asg_q  <= 1'b0;
			c1_bsg_q  <= 1'b0;
			c1_shl_q  <= 1'b0;
			c1_fast_q <= 1'b0;
		end
		else if (adv)
		begin
			c1_v_q    <= take && (lnk.op != fcp_pkg::FCP_OP_NOP);
			c1_op_q   <= take ? fcp_pkg::fcp_op_t'(lnk.op) : fcp_pkg::FCP_OP_NOP;
			if (take)
			begin
				c1_asg_q  <= lnk.operand_a_signed_sel;
				c1_bsg_q  <= lnk.operand_b_signed_sel;
				c1_shl_q  <= lnk.product_shift_left;
				c1_fast_q <= lnk.fast_mode;
			end
		end
	end

	// Operation time counter; reset aborts a multicycle operation
	always_ff @(posedge lnk.pclk or negedge lnk.reset_n)
	begin
		if (!lnk.reset_n)
			cnt_q <= 3'h0;
		else if (adv)
		begin
			if (take && (lnk.op == fcp_pkg::FCP_OP_MULTI))
				cnt_q <= fcp_pkg::OP_TIME;
			else if (blk)
				cnt_q <= cnt_q - fcp_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge lnk.pclk or negedge lnk.reset_n)
	begin
		if (!lnk.reset_n)
		begin
			s2_v_q     <= 1'b0;
			s2_op_q    <= fcp_pkg::FCP_OP_NOP;
			s2_shl_q   <= 1'b0;
			s2_flush_q <= 1'b0;
			valid_q    <= 1'b0;
			flush_q    <= 1'b0;
		end
		else
		begin
			valid_q <= fire;
			flush_q <= fire && s2_flush_q;
			if (adv && !s2_st)
			begin
				s2_v_q     <= c1_v_q;
				s2_op_q    <= c1_op_q;
				s2_shl_q   <= c1_shl_q;
				s2_flush_q <= c1_v_q && (c1_op_q == fcp_pkg::FCP_OP_FLT) && f_flush;
			end
		end
	end

	// Data stages carry no reset so that reset leaves results untouched
	always_ff @(posedge lnk.pclk)
	begin
		if (take)
		begin
			c1_a_q <= opnd_a;
			c1_b_q <= opnd_b;
		end
		if (adv && !s2_st)
		begin
			s2_prod_q <= fx_prod;
			s2_flt_q  <= f_res;
		end
		if (fire)
			dout_q <= dout_d;
	end

	assign lnk.dout       = dout_q;
	assign lnk.dout_valid = valid_q;
	assign busy           = blk;
	assign flush_zero     = flush_q;
endmodule
`default_nettype wire

// ===== verilog/fcp_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_sequencer (
	fcp_link_if.seq     lnk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [31:0]       ctrl_q;
	logic [7:0]        sel_q;
	logic [31:0]       datay_q;
	logic [31:0]       px_q;
	logic [31:0]       py_q;
	logic [63:0]       res_q;
	logic              done_q;
	logic              go_q;
	logic              rstn_q;
	logic [31:0]       prdata_q;
	fcp_pkg::fcp_ld_t  st_q;
	fcp_pkg::fcp_ld_t  st_d;

	wire a_ctrl  = (paddr == fcp_pkg::A_CTRL);
	wire a_go    = (paddr == fcp_pkg::A_GO);
	wire a_sel   = (paddr == fcp_pkg::A_SEL);
	wire a_datax = (paddr == fcp_pkg::A_DATAX);
	wire a_datay = (paddr == fcp_pkg::A_DATAY);
	wire a_reslo = (paddr == fcp_pkg::A_RESLO);
	wire a_reshi = (paddr == fcp_pkg::A_RESHI);
	wire a_stat  = (paddr == fcp_pkg::A_STAT);
	wire mapped  = a_ctrl || a_go || a_sel || a_datax || a_datay || a_reslo || a_reshi || a_stat;
	// Loads and port changes wait until the previous load or guard has finished
	wire stall   = pwrite && (a_ctrl || a_datax) && (st_q != fcp_pkg::FCP_LD_IDLE);
	wire acc     = psel && penable && !stall;
	wire wr      = acc && pwrite && mapped;
	wire cfg_chg = wr && a_ctrl &&
	               (pwdata[fcp_pkg::C_CFG +: 2] != ctrl_q[fcp_pkg::C_CFG +: 2]);
	wire mixed   = ctrl_q[fcp_pkg::C_ASG] != ctrl_q[fcp_pkg::C_BSG];

	wire [31:0] rd_mux = a_ctrl  ? ctrl_q :
	                     a_sel   ? {24'h0, sel_q} :
	                     a_datay ? datay_q :
	                     a_reslo ? res_q[31:0] :
	                     a_reshi ? res_q[63:32] :
	                     a_stat  ? {30'h0, st_q != fcp_pkg::FCP_LD_IDLE, done_q} : 32'h0;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			fcp_pkg::FCP_LD_IDLE:
				if (cfg_chg)
					st_d = fcp_pkg::FCP_LD_GUARD;
				else if (wr && a_datax)
					st_d = fcp_pkg::FCP_LD_LOAD;
			fcp_pkg::FCP_LD_LOAD:  st_d = fcp_pkg::FCP_LD_KEEP;
			fcp_pkg::FCP_LD_GUARD: st_d = fcp_pkg::FCP_LD_KEEP;
			fcp_pkg::FCP_LD_KEEP:  st_d = fcp_pkg::FCP_LD_IDLE;
			default:               st_d = fcp_pkg::FCP_LD_IDLE;
		endcase
	end

	always_ff @(posedge lnk.pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= fcp_pkg::CTRL_RST;
			sel_q  <= 8'h00;
			done_q <= 1'b0;
			go_q   <= 1'b0;
			rstn_q <= 1'b0;
			st_q   <= fcp_pkg::FCP_LD_IDLE;
		end
		else
		begin
			st_q   <= st_d;
			go_q   <= wr && a_go;
			rstn_q <= !ctrl_q[fcp_pkg::C_RST];
			if (wr && a_ctrl)
				ctrl_q <= pwdata;
			if (wr && a_sel)
				sel_q <= pwdata[7:0];
			// A finishing result beats a simultaneous clear
			if (lnk.dout_valid)
				done_q <= 1'b1;
			else if (wr && a_stat && pwdata[fcp_pkg::ST_DONE])
				done_q <= 1'b0;
		end
	end

	// Data path registers; no reset needed
	always_ff @(posedge lnk.pclk)
	begin
		if (psel && !penable)
			prdata_q <= rd_mux;
		if (wr && a_datay)
			datay_q <= pwdata;
		if (wr && a_datax)
		begin
			px_q <= pwdata;
			py_q <= datay_q;
		end
		if (lnk.dout_valid)
			res_q <= lnk.dout;
	end

	assign prdata  = prdata_q;
	assign pready  = !stall;
	assign pslverr = psel && penable && !mapped;

	assign lnk.reset_n              = rstn_q;
	assign lnk.hold_n               = !ctrl_q[fcp_pkg::C_HOLD];
	assign lnk.operand_a_signed_sel = ctrl_q[fcp_pkg::C_ASG];
	assign lnk.operand_b_signed_sel = ctrl_q[fcp_pkg::C_BSG];
	// Mixed products keep bit 62 meaningful, so no shift for them
	assign lnk.product_shift_left   = ctrl_q[fcp_pkg::C_SHL] && !mixed;
	assign lnk.fast_mode            = ctrl_q[fcp_pkg::C_FAST] && !ctrl_q[fcp_pkg::C_GRAD];
	assign lnk.op                   = go_q ? ctrl_q[fcp_pkg::C_OP +: 2] : 2'h0;
	assign lnk.rd_a                 = ctrl_q[fcp_pkg::C_RDA +: 2];
	assign lnk.rd_b                 = ctrl_q[fcp_pkg::C_RDB +: 2];
	assign lnk.input_port_config    = ctrl_q[fcp_pkg::C_CFG +: 2];
	assign lnk.register_load_select = (st_q == fcp_pkg::FCP_LD_LOAD) ? sel_q : 8'h00;
	assign lnk.port_x               = px_q;
	assign lnk.port_y               = py_q;
endmodule
`default_nettype wire

// ===== tb/fcp_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_link_props (
	input wire logic        pclk,
	input wire logic        reset_n,
	input wire logic        hold_n,
	input wire logic        operand_a_signed_sel,
	input wire logic        operand_b_signed_sel,
	input wire logic        product_shift_left,
	input wire logic [1:0]  op,
	input wire logic [1:0]  input_port_config,
	input wire logic [7:0]  register_load_select,
	input wire logic [63:0] dout,
	input wire logic        dout_valid
);
	logic [2:0] mc_q;
	logic [2:0] mc_d;
	wire        take = hold_n && (mc_q == 3'h0);
	wire        is_multi = (op == fcp_pkg::FCP_OP_MULTI);
	wire        is_single = (op == fcp_pkg::FCP_OP_FIX) || (op == fcp_pkg::FCP_OP_FLT);

	// Shadow of the multicycle window, so single-op latency checks skip it
	assign mc_d = (mc_q != 3'h0) ? mc_q - 3'h1 : (is_multi ? 3'h4 : 3'h0);
	always_ff @(posedge pclk or negedge reset_n)
	begin
		if (!reset_n)
			mc_q <= 3'h0;
		else if (hold_n)
			mc_q <= mc_d;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!reset_n);

	valid_single_a: assert property ((is_single && take) |-> ##3 dout_valid)
		else $error("single op result late");
	shift_zero_a: assert property ((op == fcp_pkg::FCP_OP_FIX && product_shift_left && take)
		|-> ##3 (dout_valid && !dout[0]))
		else $error("shifted product lsb not zero");
	multi_lat_a: assert property ((is_multi && take) |-> ##1 !dout_valid [*4] ##1 dout_valid)
		else $error("multicycle timing wrong");
	hold_freeze_a: assert property ((!hold_n ##1 !hold_n) |-> $stable(dout))
		else $error("output moved while held");
	cfg_guard_a: assert property ($changed(input_port_config)
		|-> register_load_select == 8'h00 ##1 register_load_select == 8'h00)
		else $error("select active during port change");
	sel_once_a: assert property ((register_load_select != 8'h00) |=> register_load_select == 8'h00)
		else $error("select held too long");
	rst_clear_a: assert property ($rose(reset_n) |-> !dout_valid [*2])
		else $error("valid after reset");
	mixed_shift_a: assert property ((operand_a_signed_sel != operand_b_signed_sel)
		|-> !product_shift_left)
		else $error("shift on mixed product");

	cover property (is_multi && take);
	cover property ($changed(input_port_config));
	cover property (!hold_n ##1 !hold_n);
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic        flush_zero;
	logic [31:0] rdat;
	logic        rerr;
	int          err_count = 0;
	int          cmp_count = 0;
	int          flush_seen = 0;

	always #50 pclk = ~pclk;

	// Flush flag is a one-cycle pulse, so count it as it goes by
	always @(posedge pclk)
		if (flush_zero === 1'b1)
			flush_seen++;

	fcp_link_if lnk (.pclk(pclk));
	fcp_device fcp_device_inst (.lnk(lnk.dev), .busy(busy), .flush_zero(flush_zero));
	fcp_sequencer fcp_sequencer_inst (.lnk(lnk.seq), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	fcp_link_props fcp_link_props_inst (.pclk(lnk.pclk), .reset_n(lnk.reset_n),
		.hold_n(lnk.hold_n), .operand_a_signed_sel(lnk.operand_a_signed_sel),
		.operand_b_signed_sel(lnk.operand_b_signed_sel),
		.product_shift_left(lnk.product_shift_left), .op(lnk.op),
		.input_port_config(lnk.input_port_config),
		.register_load_select(lnk.register_load_select), .dout(lnk.dout),
		.dout_valid(lnk.dout_valid));

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Master waits on pready without assuming a wait-state count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Control word: flags are sign a, sign b, shift, fast; x is reset, hold, gradual
	function automatic logic [31:0] cw(input logic [1:0] o, input logic [3:0] f,
		input logic [1:0] c, input logic [2:0] x);
		cw = {17'h0, x, c, 4'h0, o, f};
	endfunction

	// A0 and B0 selected together so one load fills both: X and Y in two-port modes, one port's word in one-port modes
	task automatic load(input logic [31:0] c, input logic [31:0] x, input logic [31:0] y);
		wr(fcp_pkg::A_CTRL, c);
		wr(fcp_pkg::A_STAT, 32'h1);
		wr(fcp_pkg::A_SEL, 32'h11);
		wr(fcp_pkg::A_DATAY, y);
		wr(fcp_pkg::A_DATAX, x);
	endtask

	task automatic fin(input logic [63:0] e);
		logic [31:0] lo;
		int          n;
		wr(fcp_pkg::A_GO, 32'h0);
		n = 0;
		do
		begin
			rd(fcp_pkg::A_STAT);
			n++;
		end
		while (rdat[0] !== 1'b1 && n < 40);
		rd(fcp_pkg::A_RESLO);
		lo = rdat;
		rd(fcp_pkg::A_RESHI);
		`CHK("product", e, {rdat, lo})
	endtask

	task automatic mul(input logic [31:0] c, input logic [31:0] x, input logic [31:0] y,
		input logic [63:0] e);
		load(c, x, y);
		fin(e);
	endtask

	task automatic t_bus();
		rd(fcp_pkg::A_CTRL);
		`CHK("ctrl reset", fcp_pkg::CTRL_RST, rdat)
		rd(8'h20);
		`CHK("unmapped err", 1'b1, rerr)
		`CHK("unmapped data", 32'h0, rdat)
		$display("test bus done");
	endtask

	task automatic t_fixed();
		mul(cw(2'h1, 4'h0, 2'h0, 3'h0), 32'hFFFFFFFF, 32'hFFFFFFFF, 64'hFFFFFFFE00000001);
		mul(cw(2'h1, 4'h4, 2'h0, 3'h0), 32'hFFFFFFFF, 32'hFFFFFFFF, 64'hFFFFFFFC00000002);
		mul(cw(2'h1, 4'h7, 2'h0, 3'h0), 32'h80000000, 32'h80000000, 64'h8000000000000000);
		mul(cw(2'h1, 4'h3, 2'h0, 3'h0), 32'h80000000, 32'h80000000, 64'h4000000000000000);
		mul(cw(2'h1, 4'h5, 2'h0, 3'h0), 32'hFFFFFFFF, 32'h00000002, 64'hFFFFFFFFFFFFFFFE);
		mul(cw(2'h2, 4'h0, 2'h0, 3'h0), 32'h00000003, 32'h00000005, 64'h000000000000000F);
		$display("test fixed done");
	endtask

	task automatic t_ports();
		mul(cw(2'h1, 4'h0, 2'h1, 3'h0), 32'h00000007, 32'h00000005, 64'h31);
		mul(cw(2'h1, 4'h0, 2'h2, 3'h0), 32'h00000009, 32'h00000006, 64'h24);
		mul(cw(2'h1, 4'h0, 2'h3, 3'h0), 32'h00000004, 32'h00000006, 64'h18);
		$display("test ports done");
	endtask

	task automatic t_float();
		mul(cw(2'h3, 4'h8, 2'h0, 3'h0), 32'h3F800000, 32'h40000000, 64'h40000000);
		mul(cw(2'h3, 4'h8, 2'h0, 3'h0), 32'h00000001, 32'h3F800000, 64'h0);
		mul(cw(2'h3, 4'h8, 2'h0, 3'h0), 32'h00C00000, 32'h3F000000, 64'h0);
		`CHK("flush count", 2, flush_seen)
		wr(fcp_pkg::A_CTRL, cw(2'h3, 4'h8, 2'h0, 3'h4));
		// The control write lands at the access edge; look once it has settled
		@(posedge pclk);
		`CHK("fast forced", 1'b0, lnk.fast_mode)
		$display("test float done");
	endtask

	task automatic t_hold();
		wr(fcp_pkg::A_CTRL, cw(2'h1, 4'h0, 2'h0, 3'h2));
		wr(fcp_pkg::A_STAT, 32'h1);
		wr(fcp_pkg::A_GO, 32'h0);
		repeat (8) @(posedge pclk);
		rd(fcp_pkg::A_STAT);
		`CHK("held done", 1'b0, rdat[0])
		wr(fcp_pkg::A_CTRL, cw(2'h1, 4'h0, 2'h0, 3'h0));
		$display("test hold done");
	endtask

	// Abort a multicycle product, then reuse the untouched operands
	task automatic t_reset();
		load(cw(2'h2, 4'h0, 2'h0, 3'h0), 32'h00000003, 32'h00000005);
		wr(fcp_pkg::A_GO, 32'h0);
		wr(fcp_pkg::A_CTRL, cw(2'h2, 4'h0, 2'h0, 3'h1));
		`CHK("busy in op", 1'b1, busy)
		wr(fcp_pkg::A_CTRL, cw(2'h1, 4'h0, 2'h0, 3'h0));
		repeat (8) @(posedge pclk);
		`CHK("busy aborted", 1'b0, busy)
		rd(fcp_pkg::A_STAT);
		`CHK("aborted done", 1'b0, rdat[0])
		fin(64'hF);
		$display("test reset done");
	endtask

	initial
	begin
		#2000000;
		err_count++;
		close_out();
	end

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_bus();
		t_fixed();
		t_ports();
		t_float();
		t_hold();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
